//--- bench/rdt_diode_model.sv
// Remote diode and converter model
`timescale 1ns/10ps
module rdt_diode_model
(
  input  wire       mclk_i,      // Clock
  input  wire       sys_rst_i,   // Reset
  input  wire       adc_start_i, // Start
  input  wire       exc_chan_i,  // Channel
  input  wire [9:0] t1_i,        // Remote 1, quarters
  input  wire [9:0] t2_i,        // Remote 2, quarters
  input  wire [9:0] ser_i,       // Series error per step
  input  wire [9:0] dly_i,       // Answer latency
  output reg        adc_done_o,  // Done pulse
  output reg  [9:0] adc_data_o   // Result
);
  reg  [9:0] cnt_q;
  reg        ph_q;
  reg        par_q;
  wire [9:0] base = exc_chan_i ? t2_i : t1_i;
  wire [9:0] noise = par_q ? 10'h002 : 10'h3fe;

  // Answer after the latency; idle data keeps changing
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= 10'h000;
      ph_q <= 1'b0;
      par_q <= 1'b0;
      adc_done_o <= 1'b0;
      adc_data_o <= 10'h000;
    end
    else
    begin
      adc_done_o <= 1'b0;
      adc_data_o <= ~adc_data_o;
      if (adc_start_i)
        cnt_q <= dly_i;
      else if (cnt_q != 10'h000)
      begin
        cnt_q <= cnt_q - 10'h001;
        if (cnt_q == 10'h001)
        begin
          adc_done_o <= 1'b1;
          ph_q <= ~ph_q;
          par_q <= par_q ^ ph_q;
          adc_data_o <= ph_q ? base + ser_i + ser_i : base + ser_i + noise;
        end
      end
    end
  end
endmodule

//--- bench/rdt_readout_monitor.sv
// Port assertions for the remote readout
`timescale 1ns/10ps
module rdt_readout_monitor
(
  input wire       mclk_i,      // Clock
  input wire       sys_rst_i,   // Reset
  input wire [7:0] reg_addr_i,  // Address
  input wire [7:0] reg_wdata_i, // Write data
  input wire       reg_wr_i,    // Write
  input wire       reg_rd_i,    // Read
  input wire [7:0] reg_rdata_o, // Read data
  input wire       adc_start_o, // Start
  input wire [6:0] exc_ua_o,    // Excitation
  input wire       exc_chan_o   // Channel
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  reg       base_q;   // Last nonzero step was the base
  reg [7:0] hold_q;   // Cycles since last base/multiple swap

  // Track swaps between base and multiple steps
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      base_q <= 1'b1;
      hold_q <= 8'hff;
    end
    else if (exc_ua_o != 7'h00 && (exc_ua_o == 7'h06) != base_q)
    begin
      base_q <= (exc_ua_o == 7'h06);
      hold_q <= 8'h00;
    end
    else if (hold_q != 8'hff)
    begin
      hold_q <= hold_q + 8'h01;
    end
  end

  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_unmapped;
    $past(reg_rd_i) && $past(reg_addr_i) == 8'h00 |-> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_frac_rsvd;
    $past(reg_rd_i) && $past(reg_addr_i) == 8'h77 |-> reg_rdata_o[5:4] == 2'h0 && reg_rdata_o[1:0] == 2'h0;
  endproperty
  a_frac_rsvd: assert property (p_frac_rsvd) else $error("fraction spare bits set");
  property p_ofs_back;
    $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 8'h70 && $past(reg_rd_i) && $past(reg_addr_i) == 8'h70
      |-> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_ofs_back: assert property (p_ofs_back) else $error("offset readback wrong");
  property p_exc_set;
    exc_ua_o inside {7'h00, 7'h06, 7'h24, 7'h60};
  endproperty
  a_exc_set: assert property (p_exc_set) else $error("bad excitation step");
  property p_start_pulse;
    adc_start_o |=> !adc_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_start_exc;
    adc_start_o |-> ##[0:2] exc_ua_o != 7'h00;
  endproperty
  a_start_exc: assert property (p_start_exc) else $error("no excitation after start");
  property p_chop_hold;
    exc_ua_o != 7'h00 && (exc_ua_o == 7'h06) != base_q |-> hold_q >= 8'h64;
  endproperty
  a_chop_hold: assert property (p_chop_hold) else $error("excitation step too short");
  property p_chan_idle;
    $changed(exc_chan_o) |=> exc_ua_o == 7'h00;
  endproperty
  a_chan_idle: assert property (p_chan_idle) else $error("channel switched under excitation");
endmodule

bind rdt_remote_readout rdt_readout_monitor i_rdt_readout_monitor
(
  .mclk_i      (mclk_i),
  .sys_rst_i   (sys_rst_i),
  .reg_addr_i  (reg_addr_i),
  .reg_wdata_i (reg_wdata_i),
  .reg_wr_i    (reg_wr_i),
  .reg_rd_i    (reg_rd_i),
  .reg_rdata_o (reg_rdata_o),
  .adc_start_o (adc_start_o),
  .exc_ua_o    (exc_ua_o),
  .exc_chan_o  (exc_chan_o)
);

//--- bench/test_rdt_remote_readout.sv
// Testbench for the remote readout
`timescale 1ns/10ps
module test_rdt_remote_readout;
  reg        mclk_i = 1'b0;
  reg        sys_rst_i = 1'b1;
  reg  [7:0] reg_addr_i = 8'h00;
  reg  [7:0] reg_wdata_i = 8'h00;
  reg        reg_wr_i = 1'b0;
  reg        reg_rd_i = 1'b0;
  reg        diode_fault_i = 1'b0;
  reg  [9:0] t1 = 10'h166;
  reg  [9:0] dly = 10'h0c8;
  wire [7:0] reg_rdata_o;
  wire       adc_start_o;
  wire       adc_done_i;
  wire [9:0] adc_data_i;
  wire [6:0] exc_ua_o;
  wire       exc_chan_o;
  wire       irq_o;
  integer    n_errors = 0;
  integer    cmp_count = 0;
  integer    k;
  reg  [7:0] rv;
  reg  [7:0] seen;

  // Clock
  always #4 mclk_i = ~mclk_i;

  rdt_remote_readout i_rdt_remote_readout
  (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .adc_start_o(adc_start_o),
    .adc_done_i(adc_done_i), .adc_data_i(adc_data_i), .diode_fault_i(diode_fault_i),
    .exc_ua_o(exc_ua_o), .exc_chan_o(exc_chan_o), .irq_o(irq_o)
  );

  rdt_diode_model i_rdt_diode_model
  (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .adc_start_i(adc_start_o), .exc_chan_i(exc_chan_o),
    .t1_i(t1), .t2_i(10'h0e4), .ser_i(10'h020), .dly_i(dly), .adc_done_o(adc_done_i),
    .adc_data_o(adc_data_i)
  );

  task stop_test;
  begin
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  task cmp8(input [7:0] g, input [7:0] e);
  begin
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask

  // Write strobe; always followed by a read
  task wr(input [7:0] a, input [7:0] d);
  begin
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  end
  endtask

  task rd(input [7:0] a);
  begin
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 rv = reg_rdata_o;
    @(posedge mclk_i);
  end
  endtask

  task chk(input [7:0] a, input [7:0] e);
  begin
    rd(a);
    cmp8(rv, e);
  end
  endtask

  // Poll status until all bits of m were seen
  task wait_done(input [7:0] m);
  begin
    seen = 8'h00;
    k = 0;
    while ((seen & m) != m && k < 900)
    begin
      rd(8'h41);
      seen = seen | rv;
      repeat (50) @(posedge mclk_i);
      k = k + 1;
    end
    if (k >= 900)
    begin
      cmp8(seen & m, m);
      stop_test;
    end
  end
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    chk(8'h40, 8'h01);
    chk(8'h25, 8'h80);
    chk(8'h77, 8'h00);
    chk(8'h25, 8'h80);
    chk(8'h27, 8'h80);
    wr(8'h00, 8'h5a);
    chk(8'h00, 8'h00);
    wr(8'h70, 8'h03 + 8'h01);
    chk(8'h70, 8'h04);
    wr(8'h72, 8'hfe);
    chk(8'h72, 8'hfe);
    wait_done(8'h03);
    wait_done(8'h03);
    chk(8'h77, 8'h08);
    chk(8'h25, 8'h1b);
    chk(8'h27, 8'hf8);
    // Frozen values after the fraction read
    dly <= 10'h014;
    t1 <= 10'h1d1;
    chk(8'h77, 8'h08);
    wait_done(8'h03);
    wait_done(8'h03);
    chk(8'h25, 8'h1b);
    chk(8'h27, 8'hf8);
    wait_done(8'h03);
    chk(8'h77, 8'h04);
    chk(8'h25, 8'h36);
    chk(8'h27, 8'hf8);
    // Extended format
    wr(8'h40, 8'h03);
    chk(8'h40, 8'h03);
    wait_done(8'h03);
    wait_done(8'h03);
    chk(8'h77, 8'h04);
    chk(8'h25, 8'h76);
    chk(8'h27, 8'h38);
    // Interrupt raise and clear
    wr(8'h42, 8'h03);
    chk(8'h42, 8'h03);
    k = 0;
    while (irq_o !== 1'b1 && k < 20000)
    begin
      @(posedge mclk_i);
      k = k + 1;
    end
    cmp8({7'h00, irq_o}, 8'h01);
    if (k >= 20000)
      stop_test;
    rd(8'h41);
    cmp8({7'h00, irq_o}, 8'h00);
    // Diode fault, standard format, prompt answers
    dly <= 10'h008;
    wr(8'h40, 8'h01);
    chk(8'h40, 8'h01);
    diode_fault_i <= 1'b1;
    wait_done(8'h0c);
    wait_done(8'h0c);
    chk(8'h77, 8'h00);
    chk(8'h25, 8'h80);
    chk(8'h27, 8'h80);
    stop_test;
  end
endmodule

//--- design/rdt_avg.v
// Sixteen-sample accumulator producing the mean of combined measurements
`timescale 1ns/10ps
`include "rdt_defs.vh"

module rdt_avg
(
  input  wire               mclk_i,    // System clock
  input  wire               sys_rst_i, // Async reset, high
  input  wire               clr_i,     // Start a new average
  input  wire               add_i,     // Accumulate one sample
  input  wire signed [12:0] smp_i,     // Combined sample
  output reg  signed [12:0] avg_o,     // Registered mean
  output reg                done_o     // Pulse when mean valid
);

  reg signed [16:0] acc_q;
  reg        [4:0]  cnt_q;
  wire signed [16:0] sum_w = acc_q + {{4{smp_i[12]}}, smp_i};

  // Accumulate and divide by sixteen
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      acc_q  <= 17'sd0;
      cnt_q  <= 5'd0;
      avg_o  <= 13'sd0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (clr_i)
      begin
        acc_q <= 17'sd0;
        cnt_q <= 5'd0;
      end
      else if (add_i)
      begin
        if (cnt_q == `RDT_AVG_N - 1)
        begin
          avg_o  <= sum_w[16:`RDT_AVG_SHIFT];
          done_o <= 1'b1;
          acc_q  <= 17'sd0;
          cnt_q  <= 5'd0;
        end
        else
        begin
          acc_q <= sum_w;
          cnt_q <= cnt_q + 5'd1;
        end
      end
    end
  end

endmodule

//--- design/rdt_defs.vh
// Register map, field positions, reset values and timing for the remote diode readout
`ifndef RDT_DEFS_VH
`define RDT_DEFS_VH

// Register offsets
`define RDT_REG_R1_VAL    8'h25
`define RDT_REG_R2_VAL    8'h27
`define RDT_REG_CTRL      8'h40
`define RDT_REG_STAT      8'h41
`define RDT_REG_MASK      8'h42
`define RDT_REG_R1_OFS    8'h70
`define RDT_REG_R2_OFS    8'h72
`define RDT_REG_FRAC      8'h77

// Field positions
`define RDT_CTRL_RUN      0
`define RDT_CTRL_EXT      1
`define RDT_FRAC_R1_LO    2
`define RDT_FRAC_R2_LO    6
`define RDT_ST_DONE1      0
`define RDT_ST_DONE2      1
`define RDT_ST_FLT1       2
`define RDT_ST_FLT2       3

// Reset values
`define RDT_CTRL_RST      8'h01
`define RDT_MASK_RST      4'h0
`define RDT_OFS_RST       8'h00

// Excitation current steps in microamps
`define RDT_I_BASE_UA     7'd6
`define RDT_I_N1_UA       7'd36
`define RDT_I_N2_UA       7'd96

// Averaging and result codes
`define RDT_AVG_N         16
`define RDT_AVG_SHIFT     4
`define RDT_EXT_MIN       10'h004
`define RDT_EXT_ZERO      10'h100
`define RDT_STD_MAX       10'h1ff
`define RDT_FLT_STD       10'h200
`define RDT_FLT_EXT       10'h000

// Chop timing
`define RDT_CLK_NS        8
`define RDT_CHOP_NS       1000
`define RDT_CHOP_CYC      ((`RDT_CHOP_NS + `RDT_CLK_NS - 1) / `RDT_CLK_NS)

`endif

//--- design/rdt_remote_readout.v
// Remote diode readout: excitation sequencing, averaging, formatting and registers
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "rdt_defs.vh"

module rdt_remote_readout
(
  input  wire        mclk_i,        // System clock, 125 MHz
  input  wire        sys_rst_i,     // Async reset, high
  input  wire [7:0]  reg_addr_i,    // Register address
  input  wire [7:0]  reg_wdata_i,   // Register write data
  input  wire        reg_wr_i,      // Write strobe
  input  wire        reg_rd_i,      // Read strobe
  output reg  [7:0]  reg_rdata_o,   // Read data, cycle after strobe
  output reg         adc_start_o,   // Start a difference measurement
  input  wire        adc_done_i,    // Measurement finished
  input  wire [9:0]  adc_data_i,    // Temperature-scaled difference result
  input  wire        diode_fault_i, // Diode open or short, async
  output reg  [6:0]  exc_ua_o,      // Excitation current in uA
  output reg         exc_chan_o,    // Remote channel select
  output wire        irq_o          // Level interrupt
);

  localparam ST_IDLE = 3'd0;
  localparam ST_PH1  = 3'd1;
  localparam ST_PH2  = 3'd2;
  localparam ST_ACC  = 3'd3;
  localparam ST_WAIT = 3'd4;

  // Address match helper
  function hit;
    input [7:0] a;
    input [7:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  reg  [2:0]  st_q;
  reg  [7:0]  ctrl_q;
  reg  [3:0]  stat_q;
  reg  [3:0]  mask_q;
  reg  [7:0]  ofs_q [0:1];
  reg  [9:0]  rslt_q [0:1];
  reg  [9:0]  vis_q [0:1];
  reg  [9:0]  m1_q;
  reg  [9:0]  m2_q;
  reg         flt_seen_q;
  reg         frz_q;
  reg  [1:0]  unread_q;
  reg  [6:0]  chop_cnt_q;
  reg         chop_q;
  reg         flt_s1_q;
  reg         flt_s2_q;
  reg  [3:0]  ev_q;
  reg  [9:0]  code_d;
  reg  [12:0] ext_d;
  reg  [12:0] std_d;

  wire               chop_en;
  wire signed [12:0] comb_w;
  wire signed [12:0] avg_w;
  wire               avg_done;
  wire signed [12:0] ofs_q4;
  wire signed [12:0] adj_w;
  wire               rd_frac;
  wire               rd_r1;
  wire               rd_r2;
  wire               rd_stat;

  assign rd_frac = reg_rd_i & hit(reg_addr_i, `RDT_REG_FRAC);
  assign rd_r1   = reg_rd_i & hit(reg_addr_i, `RDT_REG_R1_VAL);
  assign rd_r2   = reg_rd_i & hit(reg_addr_i, `RDT_REG_R2_VAL);
  assign rd_stat = reg_rd_i & hit(reg_addr_i, `RDT_REG_STAT);

  // Fault pin synchroniser
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      flt_s1_q <= 1'b0;
      flt_s2_q <= 1'b0;
    end
    else
    begin
      flt_s1_q <= diode_fault_i;
      flt_s2_q <= flt_s1_q;
    end
  end

  // Chop rate divider
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      chop_cnt_q <= 7'd0;
    end
    else if (chop_cnt_q == `RDT_CHOP_CYC - 1)
    begin
      chop_cnt_q <= 7'd0;
    end
    else
    begin
      chop_cnt_q <= chop_cnt_q + 7'd1;
    end
  end
  assign chop_en = (chop_cnt_q == `RDT_CHOP_CYC - 1);

  // Two-point extrapolation removes series resistance error
  assign comb_w = $signed({3'b000, m1_q} <<< 1) - $signed({3'b000, m2_q});

  rdt_avg u_avg
  (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .clr_i     (st_q == ST_IDLE),
    .add_i     (st_q == ST_ACC),
    .smp_i     (comb_w),
    .avg_o     (avg_w),
    .done_o    (avg_done)
  );

  // Offset in 0.5 C steps scaled to quarter degrees
  assign ofs_q4 = {{4{ofs_q[exc_chan_o][7]}}, ofs_q[exc_chan_o], 1'b0};
  assign adj_w  = avg_w + ofs_q4;

  // Clamp and format the averaged result
  always @*
  begin
    ext_d = adj_w;
    if (adj_w < $signed({3'b000, `RDT_EXT_MIN}))
    begin
      ext_d = {3'b000, `RDT_EXT_MIN};
    end
    else if (adj_w > 13'sd1023)
    begin
      ext_d = 13'sd1023;
    end
    std_d = ext_d - {3'b000, `RDT_EXT_ZERO};
    if ($signed(std_d) > $signed({3'b000, `RDT_STD_MAX}))
    begin
      std_d = {3'b000, `RDT_STD_MAX};
    end
    if (ctrl_q[`RDT_CTRL_EXT])
    begin
      code_d = flt_seen_q ? `RDT_FLT_EXT : ext_d[9:0];
    end
    else
    begin
      code_d = flt_seen_q ? `RDT_FLT_STD : std_d[9:0];
    end
  end

  // Conversion sequencer
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_q        <= ST_IDLE;
      adc_start_o <= 1'b0;
      exc_ua_o    <= 7'd0;
      exc_chan_o  <= 1'b0;
      chop_q      <= 1'b0;
      m1_q        <= 10'h000;
      m2_q        <= 10'h000;
      flt_seen_q  <= 1'b0;
      rslt_q[0]   <= `RDT_FLT_STD;
      rslt_q[1]   <= `RDT_FLT_STD;
      ev_q        <= 4'h0;
    end
    else
    begin
      adc_start_o <= 1'b0;
      ev_q        <= 4'h0;
      if (chop_en)
      begin
        chop_q <= ~chop_q;
      end
      if (st_q != ST_IDLE && flt_s2_q)
      begin
        flt_seen_q <= 1'b1;
      end
      case (st_q)
        ST_IDLE:
        begin
          exc_ua_o   <= 7'd0;
          flt_seen_q <= 1'b0;
          if (ctrl_q[`RDT_CTRL_RUN])
          begin
            st_q        <= ST_PH1;
            adc_start_o <= 1'b1;
          end
        end
        ST_PH1:
        begin
          exc_ua_o <= chop_q ? `RDT_I_N1_UA : `RDT_I_BASE_UA;
          if (adc_done_i)
          begin
            m1_q        <= adc_data_i;
            st_q        <= ST_PH2;
            adc_start_o <= 1'b1;
          end
        end
        ST_PH2:
        begin
          exc_ua_o <= chop_q ? `RDT_I_N2_UA : `RDT_I_BASE_UA;
          if (adc_done_i)
          begin
            m2_q <= adc_data_i;
            st_q <= ST_ACC;
          end
        end
        ST_ACC:
        begin
          st_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (avg_done)
          begin
            rslt_q[exc_chan_o] <= code_d;
            ev_q[exc_chan_o]   <= 1'b1;
            ev_q[exc_chan_o + 2'd2] <= flt_seen_q;
            exc_chan_o         <= ~exc_chan_o;
            st_q               <= ST_IDLE;
          end
          else
          begin
            st_q        <= ST_PH1;
            adc_start_o <= 1'b1;
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Freeze tracking for coherent 10-bit reads
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      frz_q    <= 1'b0;
      unread_q <= 2'b00;
    end
    else if (rd_frac)
    begin
      frz_q    <= 1'b1;
      unread_q <= 2'b11;
    end
    else if (frz_q)
    begin
      unread_q <= unread_q & ~{rd_r2, rd_r1};
      if ((unread_q & ~{rd_r2, rd_r1}) == 2'b00)
      begin
        frz_q <= 1'b0;
      end
    end
  end

  // Visible copies follow results unless frozen
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      vis_q[0] <= `RDT_FLT_STD;
      vis_q[1] <= `RDT_FLT_STD;
    end
    else if (!frz_q && !rd_frac)
    begin
      vis_q[0] <= rslt_q[0];
      vis_q[1] <= rslt_q[1];
    end
  end

  // Register writes
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_q   <= `RDT_CTRL_RST;
      mask_q   <= `RDT_MASK_RST;
      ofs_q[0] <= `RDT_OFS_RST;
      ofs_q[1] <= `RDT_OFS_RST;
    end
    else if (reg_wr_i)
    begin
      if (hit(reg_addr_i, `RDT_REG_CTRL))
      begin
        ctrl_q <= {6'd0, reg_wdata_i[1:0]};
      end
      if (hit(reg_addr_i, `RDT_REG_MASK))
      begin
        mask_q <= reg_wdata_i[3:0];
      end
      if (hit(reg_addr_i, `RDT_REG_R1_OFS))
      begin
        ofs_q[0] <= reg_wdata_i;
      end
      if (hit(reg_addr_i, `RDT_REG_R2_OFS))
      begin
        ofs_q[1] <= reg_wdata_i;
      end
    end
  end

  // Sticky status, read clears, new event wins
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stat_q <= 4'h0;
    end
    else
    begin
      stat_q <= (rd_stat ? 4'h0 : stat_q) | ev_q;
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // Read data, valid one cycle after the strobe only
  always @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (!reg_rd_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      case (reg_addr_i)
        `RDT_REG_R1_VAL: reg_rdata_o <= vis_q[0][9:2];
        `RDT_REG_R2_VAL: reg_rdata_o <= vis_q[1][9:2];
        `RDT_REG_FRAC:   reg_rdata_o <= {vis_q[1][1:0], 2'b00, vis_q[0][1:0], 2'b00};
        `RDT_REG_CTRL:   reg_rdata_o <= ctrl_q;
        `RDT_REG_STAT:   reg_rdata_o <= {4'h0, stat_q};
        `RDT_REG_MASK:   reg_rdata_o <= {4'h0, mask_q};
        `RDT_REG_R1_OFS: reg_rdata_o <= ofs_q[0];
        `RDT_REG_R2_OFS: reg_rdata_o <= ofs_q[1];
        default:         reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule
